// ---- common/sbt_pkg.sv ----
package sbt_pkg;
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDREAD = 3'h1;
    localparam logic [2:0] INS_SAMPZ = 3'h2;
    localparam logic [2:0] INS_PRELOAD = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam logic [2:0] TMS_RESET_COUNT = 3'h5;
    // arbitrary neutral identification value, bit 0 set as the presence marker
    localparam logic [31:0] ID_CODE_DEFAULT = 32'h0000_0001;
    localparam logic [15:0] ST_RESET = 16'h0001;
    localparam logic [15:0] ST_IDLE = 16'h0002;
    localparam logic [15:0] ST_SEL_DR = 16'h0004;
    localparam logic [15:0] ST_CAP_DR = 16'h0008;
    localparam logic [15:0] ST_SH_DR = 16'h0010;
    localparam logic [15:0] ST_EX1_DR = 16'h0020;
    localparam logic [15:0] ST_PA_DR = 16'h0040;
    localparam logic [15:0] ST_EX2_DR = 16'h0080;
    localparam logic [15:0] ST_UP_DR = 16'h0100;
    localparam logic [15:0] ST_SEL_IR = 16'h0200;
    localparam logic [15:0] ST_CAP_IR = 16'h0400;
    localparam logic [15:0] ST_SH_IR = 16'h0800;
    localparam logic [15:0] ST_EX1_IR = 16'h1000;
    localparam logic [15:0] ST_PA_IR = 16'h2000;
    localparam logic [15:0] ST_EX2_IR = 16'h4000;
    localparam logic [15:0] ST_UP_IR = 16'h8000;
    typedef enum logic [15:0] {
        SBT_RESET = ST_RESET, SBT_IDLE = ST_IDLE, SBT_SEL_DR = ST_SEL_DR,
        SBT_CAP_DR = ST_CAP_DR, SBT_SH_DR = ST_SH_DR, SBT_EX1_DR = ST_EX1_DR,
        SBT_PA_DR = ST_PA_DR, SBT_EX2_DR = ST_EX2_DR, SBT_UP_DR = ST_UP_DR,
        SBT_SEL_IR = ST_SEL_IR, SBT_CAP_IR = ST_CAP_IR, SBT_SH_IR = ST_SH_IR,
        SBT_EX1_IR = ST_EX1_IR, SBT_PA_IR = ST_PA_IR, SBT_EX2_IR = ST_EX2_IR,
        SBT_UP_IR = ST_UP_IR
    } sbt_state_t;
endpackage : sbt_pkg

// ---- common/sbt_tap_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface sbt_tap_if;
    sbt_pkg::sbt_state_t state;
    logic rise;
    logic fall;
    logic tms;
    modport ctl (output state, input rise, input fall, input tms);
    modport use_side (input state, output rise, output fall, output tms);
endinterface : sbt_tap_if
`default_nettype wire

// ---- src/sbt_fsm.sv ----
`timescale 1ns/10ps
`default_nettype none
module sbt_fsm (
    input wire logic clk,
    input wire logic nrst,
    sbt_tap_if.ctl tap
);
    sbt_pkg::sbt_state_t state;
    sbt_pkg::sbt_state_t next_state;

    assign tap.state = state;

    always_comb begin
        next_state = state;
        if (tap.rise) begin
            unique case (state)
                sbt_pkg::SBT_RESET: next_state = tap.tms ? sbt_pkg::SBT_RESET : sbt_pkg::SBT_IDLE;
                sbt_pkg::SBT_IDLE: next_state = tap.tms ? sbt_pkg::SBT_SEL_DR : sbt_pkg::SBT_IDLE;
                sbt_pkg::SBT_SEL_DR: next_state = tap.tms ? sbt_pkg::SBT_SEL_IR : sbt_pkg::SBT_CAP_DR;
                sbt_pkg::SBT_CAP_DR: next_state = tap.tms ? sbt_pkg::SBT_EX1_DR : sbt_pkg::SBT_SH_DR;
                sbt_pkg::SBT_SH_DR: next_state = tap.tms ? sbt_pkg::SBT_EX1_DR : sbt_pkg::SBT_SH_DR;
                sbt_pkg::SBT_EX1_DR: next_state = tap.tms ? sbt_pkg::SBT_UP_DR : sbt_pkg::SBT_PA_DR;
                sbt_pkg::SBT_PA_DR: next_state = tap.tms ? sbt_pkg::SBT_EX2_DR : sbt_pkg::SBT_PA_DR;
                sbt_pkg::SBT_EX2_DR: next_state = tap.tms ? sbt_pkg::SBT_UP_DR : sbt_pkg::SBT_SH_DR;
                sbt_pkg::SBT_UP_DR: next_state = tap.tms ? sbt_pkg::SBT_SEL_DR : sbt_pkg::SBT_IDLE;
                sbt_pkg::SBT_SEL_IR: next_state = tap.tms ? sbt_pkg::SBT_RESET : sbt_pkg::SBT_CAP_IR;
                sbt_pkg::SBT_CAP_IR: next_state = tap.tms ? sbt_pkg::SBT_EX1_IR : sbt_pkg::SBT_SH_IR;
                sbt_pkg::SBT_SH_IR: next_state = tap.tms ? sbt_pkg::SBT_EX1_IR : sbt_pkg::SBT_SH_IR;
                sbt_pkg::SBT_EX1_IR: next_state = tap.tms ? sbt_pkg::SBT_UP_IR : sbt_pkg::SBT_PA_IR;
                sbt_pkg::SBT_PA_IR: next_state = tap.tms ? sbt_pkg::SBT_EX2_IR : sbt_pkg::SBT_PA_IR;
                sbt_pkg::SBT_EX2_IR: next_state = tap.tms ? sbt_pkg::SBT_UP_IR : sbt_pkg::SBT_SH_IR;
                sbt_pkg::SBT_UP_IR: next_state = tap.tms ? sbt_pkg::SBT_SEL_DR : sbt_pkg::SBT_IDLE;
                default: next_state = sbt_pkg::SBT_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= sbt_pkg::SBT_RESET;
        end else begin
            state <= next_state;
        end
    end
endmodule : sbt_fsm
`default_nettype wire

// ---- src/sbt_tap.sv ----
`timescale 1ns/10ps
`default_nettype none
module sbt_tap #(
    parameter int PIN_W = 8,
    parameter int PAD_W = 2,
    parameter logic [31:0] ID_CODE = sbt_pkg::ID_CODE_DEFAULT
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_oe,
    input wire logic tdi,
    input wire logic tdi_oe,
    input wire logic [PIN_W-1:0] pin_level,
    output logic tdo,
    output logic tdo_oe,
    output logic [PIN_W-1:0] pin_drive,
    output logic pin_drive_en,
    output logic ram_out_float,
    output logic [2:0] active_instr
);
    localparam int BS_W = PIN_W + PAD_W;

    sbt_tap_if tap_bus ();

    logic [1:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tmsoe_s;
    logic [1:0] tdi_s;
    logic [1:0] tdioe_s;
    logic tck_d;
    logic [2:0] ir_shift;
    logic [2:0] next_ir_shift;
    logic [2:0] ir_act;
    logic [2:0] next_ir_act;
    logic byp;
    logic next_byp;
    logic [31:0] id_sr;
    logic [31:0] next_id_sr;
    logic [BS_W-1:0] bs_sr;
    logic [BS_W-1:0] next_bs_sr;
    logic [PIN_W-1:0] bs_upd;
    logic [PIN_W-1:0] next_bs_upd;
    logic next_tdo;
    logic next_tdo_oe;
    logic tms_eff;
    logic tdi_eff;
    logic rise;
    logic fall;

    function automatic logic bs_sel(input logic [2:0] ins);
        return ins == sbt_pkg::INS_EXTEST || ins == sbt_pkg::INS_PRELOAD
            || ins == sbt_pkg::INS_SAMPZ;
    endfunction : bs_sel

    // two-stage synchronisers for tck, tms, tdi and their enables; pin_level is sampled directly
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tck_s <= 2'h0;
            tms_s <= 2'h3;
            tmsoe_s <= 2'h0;
            tdi_s <= 2'h3;
            tdioe_s <= 2'h0;
            tck_d <= 1'h0;
        end else begin
            tck_s <= {tck_s[0], tck};
            tms_s <= {tms_s[0], tms};
            tmsoe_s <= {tmsoe_s[0], tms_oe};
            tdi_s <= {tdi_s[0], tdi};
            tdioe_s <= {tdioe_s[0], tdi_oe};
            tck_d <= tck_s[1];
        end
    end

    assign rise = tck_s[1] & ~tck_d;
    assign fall = ~tck_s[1] & tck_d;
    assign tms_eff = tmsoe_s[1] ? tms_s[1] : 1'h1;
    assign tdi_eff = tdioe_s[1] ? tdi_s[1] : 1'h1;

    assign tap_bus.rise = rise;
    assign tap_bus.fall = fall;
    assign tap_bus.tms = tms_eff;

    sbt_fsm u_fsm (
        .clk(clk),
        .nrst(nrst),
        .tap(tap_bus.ctl)
    );

    always_comb begin
        next_ir_shift = ir_shift;
        next_ir_act = ir_act;
        next_byp = byp;
        next_id_sr = id_sr;
        next_bs_sr = bs_sr;
        next_bs_upd = bs_upd;
        if (rise) begin
            unique case (tap_bus.state)
                sbt_pkg::SBT_CAP_IR: next_ir_shift = {ir_shift[2], sbt_pkg::IR_CAPTURE};
                sbt_pkg::SBT_SH_IR: next_ir_shift = {tdi_eff, ir_shift[2:1]};
                sbt_pkg::SBT_CAP_DR: begin
                    if (ir_act == sbt_pkg::INS_IDREAD) begin
                        next_id_sr = ID_CODE;
                    end
                    if (bs_sel(ir_act)) begin
                        next_bs_sr = {{PAD_W{1'h1}}, pin_level};
                    end
                    if (ir_act == sbt_pkg::INS_BYPASS || !bs_sel(ir_act)
                        && ir_act != sbt_pkg::INS_IDREAD) begin
                        next_byp = 1'h0;
                    end
                end
                sbt_pkg::SBT_SH_DR: begin
                    if (ir_act == sbt_pkg::INS_IDREAD) begin
                        next_id_sr = {tdi_eff, id_sr[31:1]};
                    end else if (bs_sel(ir_act)) begin
                        next_bs_sr = {tdi_eff, bs_sr[BS_W-1:1]};
                    end else begin
                        next_byp = tdi_eff;
                    end
                end
                default: begin
                end
            endcase
        end
        if (fall) begin
            unique case (tap_bus.state)
                // preset identification read
                // first fall in reset, so even the fifth-high entry is covered
                sbt_pkg::SBT_RESET: next_ir_act = sbt_pkg::INS_IDREAD;
                sbt_pkg::SBT_UP_IR: next_ir_act = ir_shift;
                sbt_pkg::SBT_UP_DR: begin
                    if (bs_sel(ir_act)) begin
                        next_bs_upd = bs_sr[PIN_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_tdo = tdo;
        next_tdo_oe = tdo_oe;
        if (fall) begin
            next_tdo_oe = tap_bus.state == sbt_pkg::SBT_SH_DR
                || tap_bus.state == sbt_pkg::SBT_SH_IR;
            if (tap_bus.state == sbt_pkg::SBT_SH_IR) begin
                next_tdo = ir_shift[0];
            end else if (ir_act == sbt_pkg::INS_IDREAD) begin
                next_tdo = id_sr[0];
            end else if (bs_sel(ir_act)) begin
                next_tdo = bs_sr[0];
            end else begin
                next_tdo = byp;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ir_shift <= sbt_pkg::INS_IDREAD;
            ir_act <= sbt_pkg::INS_IDREAD;
            byp <= 1'h0;
            id_sr <= 32'h0000_0000;
            bs_sr <= '0;
            bs_upd <= '0;
            tdo <= 1'h0;
            tdo_oe <= 1'h0;
            pin_drive <= '0;
            pin_drive_en <= 1'h0;
            ram_out_float <= 1'h0;
            active_instr <= sbt_pkg::INS_IDREAD;
        end else begin
            ir_shift <= next_ir_shift;
            ir_act <= next_ir_act;
            byp <= next_byp;
            id_sr <= next_id_sr;
            bs_sr <= next_bs_sr;
            bs_upd <= next_bs_upd;
            tdo <= next_tdo;
            tdo_oe <= next_tdo_oe;
            pin_drive <= next_bs_upd;
            pin_drive_en <= next_ir_act == sbt_pkg::INS_EXTEST;
            ram_out_float <= next_ir_act == sbt_pkg::INS_SAMPZ;
            active_instr <= next_ir_act;
        end
    end
endmodule : sbt_tap
`default_nettype wire

// ---- tb/sbt_jtag_ctl.sv ----
`timescale 1ns/10ps
`default_nettype none
module sbt_jtag_ctl (
    output logic tck,
    output logic tms,
    output logic tms_oe,
    output logic tdi,
    output logic tdi_oe,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic fm = 1'b0;
    logic fd = 1'b0;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tms_oe = 1'b1;
        tdi = 1'b1;
        tdi_oe = 1'b1;
    end
    // one mode bit per tck, released lines toggle
    task automatic step(input logic m, input logic d, output logic [1:0] o);
        tms_oe = !fm;
        tdi_oe = !fd;
        tms = fm ? !tms : m;
        tdi = fd ? !tdi : d;
        #24 tck = 1'b1;
        o = {tdo_oe, tdo};
        #24 tck = 1'b0;
    endtask : step
    task automatic walk(input logic [7:0] p, input int n);
        logic [1:0] o;
        for (int i = 0; i < n; i++) step(p[i], 1'b1, o);
    endtask : walk
endmodule : sbt_jtag_ctl
`default_nettype wire

// ---- tb/sbt_tap_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module sbt_tap_chk #(
    parameter int PIN_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_oe,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [PIN_W-1:0] pin_drive,
    input wire logic pin_drive_en,
    input wire logic ram_out_float,
    input wire logic [2:0] active_instr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic tck_q;
    logic [2:0] hi_cnt;
    logic [2:0] next_hi_cnt;
    logic rise;
    assign rise = tck && !tck_q;
    // counts pin-level tck rises with mode select high or floating
    always_comb begin
        next_hi_cnt = hi_cnt;
        if (rise && tms_oe && !tms) next_hi_cnt = 3'h0;
        else if (rise && hi_cnt != 3'h7) next_hi_cnt = hi_cnt + 3'h1;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt <= 3'h0;
            tck_q <= 1'b0;
        end else begin
            hi_cnt <= next_hi_cnt;
            tck_q <= tck;
        end
    end
    tdo_fall_a: assert property ($changed(tdo) |-> !tck && !$past(tck))
        else $error("tdo moved while tck high");
    oe_fall_a: assert property ($changed(tdo_oe) |-> !tck && !$past(tck))
        else $error("tdo enable moved while tck high");
    instr_fall_a: assert property ($changed(active_instr) |-> !tck)
        else $error("instruction moved while tck high");
    drive_fall_a: assert property ($changed(pin_drive) |-> !tck && !$past(tck))
        else $error("pin drive moved while tck high");
    float_map_a: assert property ($stable(active_instr) |->
        ram_out_float == (active_instr == sbt_pkg::INS_SAMPZ)) else $error("float mismatch");
    extest_map_a: assert property ($stable(active_instr) |->
        pin_drive_en == (active_instr == sbt_pkg::INS_EXTEST)) else $error("drive en mismatch");
    idle_quiet_a: assert property ($stable(tck) [*8] |=>
        $stable(tdo) && $stable(tdo_oe) && $stable(active_instr)) else $error("change without tck");
    tms_reset_a: assert property (rise && (tms || !tms_oe) && hi_cnt == 3'h4 |->
        ##[1:16] active_instr == sbt_pkg::INS_IDREAD) else $error("no reset after five highs");
    cover property (rise && hi_cnt == 3'h4);
    cover property ($rose(tdo_oe));
    cover property ($rose(ram_out_float));
endmodule : sbt_tap_chk
bind sbt_tap sbt_tap_chk #(.PIN_W(PIN_W)) u_chk (.clk, .nrst, .tck, .tms, .tms_oe, .tdo,
    .tdo_oe, .pin_drive, .pin_drive_en, .ram_out_float, .active_instr);
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] pin_level = 8'h00;
    logic tck, tms, tms_oe, tdi, tdi_oe, tdo, tdo_oe, pin_drive_en, ram_out_float;
    logic [7:0] pin_drive;
    logic [2:0] active_instr;
    logic [2:0] cur = sbt_pkg::INS_IDREAD;
    logic [31:0] q;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    sbt_jtag_ctl ctl (.tck, .tms, .tms_oe, .tdi, .tdi_oe, .tdo, .tdo_oe);
    sbt_tap #(.PIN_W(8), .PAD_W(2)) uut (.clk, .nrst, .tck, .tms, .tms_oe, .tdi, .tdi_oe,
        .pin_level, .tdo, .tdo_oe, .pin_drive, .pin_drive_en, .ram_out_float, .active_instr);
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic ir(input logic [2:0] c);
        logic [1:0] o;
        ctl.walk(8'h06, 5);
        for (int i = 0; i < 3; i++) begin
            ctl.step(i == 2, c[i], o);
            if (i < 2) chk("ir capture", o, {1'b1, i == 0});
        end
        chk("instr held", active_instr, cur);
        ctl.walk(8'h01, 2);
        chk("instr", active_instr, c);
        cur = c;
    endtask : ir
    task automatic dr(input int n, input logic [31:0] d, output logic [31:0] r);
        logic [1:0] o;
        ctl.walk(8'h02, 4);
        r = '0;
        for (int i = 0; i < n; i++) begin
            ctl.step(i == n - 1, d[i], o);
            r[i] = o[0];
            chk("oe shift", o[1], 1'b1);
        end
        ctl.walk(8'h01, 2);
        ctl.step(1'b0, 1'b1, o);
        chk("oe idle", o[1], 1'b0);
    endtask : dr
    task automatic t_id;
        chk("instr reset", active_instr, sbt_pkg::INS_IDREAD);
        dr(32, 32'h0, q);
        chk("id", q, sbt_pkg::ID_CODE_DEFAULT);
        $display("test id done");
    endtask : t_id
    task automatic t_byp;
        logic [2:0] c [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
        for (int k = 0; k < 4; k++) begin
            ir(c[k]);
            dr(4, 32'hD, q);
            chk("bypass", q, 32'hA);
        end
        $display("test bypass done");
    endtask : t_byp
    task automatic t_scan;
        logic [2:0] c [3] = '{sbt_pkg::INS_PRELOAD, sbt_pkg::INS_EXTEST, sbt_pkg::INS_SAMPZ};
        pin_level = 8'hA5;
        for (int k = 0; k < 3; k++) begin
            ir(c[k]);
            dr(10, 32'h3C6, q);
            chk("scan", q, 32'h3A5);
            chk("drive", pin_drive, 8'hC6);
            chk("drive en", pin_drive_en, c[k] == sbt_pkg::INS_EXTEST);
            chk("float", ram_out_float, c[k] == sbt_pkg::INS_SAMPZ);
        end
        $display("test scan done");
    endtask : t_scan
    task automatic t_float;
        ir(sbt_pkg::INS_BYPASS);
        ctl.walk(8'h1F, 5);
        chk("tms reset", active_instr, sbt_pkg::INS_IDREAD);
        cur = sbt_pkg::INS_IDREAD;
        ir(sbt_pkg::INS_BYPASS);
        ctl.fd = 1'b1;
        dr(4, 32'h0, q);
        ctl.fd = 1'b0;
        chk("float tdi", q, 32'hE);
        ctl.fm = 1'b1;
        ctl.walk(8'h00, 5);
        ctl.fm = 1'b0;
        chk("float tms", active_instr, sbt_pkg::INS_IDREAD);
        cur = sbt_pkg::INS_IDREAD;
        ir(sbt_pkg::INS_BYPASS);
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        chk("reset instr", active_instr, sbt_pkg::INS_IDREAD);
        nrst = 1'b1;
        // idle long enough for the no-clock checks, then read id again
        repeat (12) @(negedge clk);
        dr(32, 32'h0, q);
        chk("id after reset", q, sbt_pkg::ID_CODE_DEFAULT);
        $display("test float done");
    endtask : t_float
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        t_id();
        t_byp();
        t_scan();
        t_float();
        test_done();
    end
endmodule : tb
`default_nettype wire
